// ==== verilog/sepw_top.sv ====
/*
  Two-wire slave front end with 32-byte page write.
  Assumes link_clk runs freely and oversamples the bus pins;
  the bus wire is resolved outside from sda_out and sda_oe.
*/
`default_nettype none
`include "sepw_defs.svh"

module sepw_top
#(
  parameter int ADDR_W = `SEPW_ADDR_W,
  parameter int PROG_CYCLES = `SEPW_T_PROG_US * `SEPW_CLK_MHZ,
  parameter logic [3:0] DEV_TYPE = `SEPW_DEV_TYPE_DFLT
)(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic link_clk,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic select_strap_bit0,
  input wire logic select_strap_bit1,
  input wire logic select_strap_bit2,
  input wire logic write_protect,
  input wire logic [ADDR_W-1:0] mem_rd_addr,
  output var sepw_pkg::sepw_byte_t mem_rd_data,
  output logic prog_busy
);
  import sepw_pkg::*;

  localparam int PW = `SEPW_PAGE_W;
  localparam int BW = `SEPW_BYTE_W;

  // Array depth must leave room for a high address byte
  if (ADDR_W < `SEPW_ADDR_W_MIN || ADDR_W > `SEPW_ADDR_W_MAX) begin : g_chk_aw
    $error("ADDR_W out of range");
  end
  if (PROG_CYCLES < 1) begin : g_chk_pc
    $error("PROG_CYCLES must be positive");
  end

  logic lrst_m_q, lrst_q;
  logic scl_m_q, scl_s_q, scl_p_q;
  logic sda_m_q, sda_s_q, sda_p_q;
  logic [`SEPW_SEL_W-1:0] strap_m_q, strap_s_q;
  logic done_m_q, done_s_q, done_p_q;
  sepw_state_t state_q;
  sepw_idx_t byte_idx_q;
  logic [3:0] bit_cnt_q;
  sepw_byte_t shreg_q;
  logic rd_q;
  logic sda_oe_q, sda_out_q;
  logic [ADDR_W-1:0] addr_cnt_q;
  logic [`SEPW_PAGE_BYTES-1:0][BW-1:0] buf_q;
  logic [`SEPW_PAGE_BYTES-1:0] mask_q;
  logic data_seen_q;
  logic busy_q;
  logic req_tgl_q;
  logic done_tgl;
  logic scl_rise, scl_fall, start_det, stop_det;
  logic byte_done, addr_hit, give_ack, store_data, done_evt;

  // Link reset: asserts at once, releases on link_clk
  always_ff @(posedge link_clk or negedge reset_n) begin
    if (!reset_n) begin
      lrst_m_q <= 1'b0;
      lrst_q <= 1'b0;
    end else begin
      lrst_m_q <= 1'b1;
      lrst_q <= lrst_m_q;
    end
  end

  // Pin synchronisers; the third stage only serves edge detection
  always_ff @(posedge link_clk or negedge lrst_q) begin
    if (!lrst_q) begin
      scl_m_q <= 1'b1;
      scl_s_q <= 1'b1;
      scl_p_q <= 1'b1;
      sda_m_q <= 1'b1;
      sda_s_q <= 1'b1;
      sda_p_q <= 1'b1;
      strap_m_q <= '0;
      strap_s_q <= '0;
    end else begin
      scl_m_q <= scl_in;
      scl_s_q <= scl_m_q;
      scl_p_q <= scl_s_q;
      sda_m_q <= sda_in;
      sda_s_q <= sda_m_q;
      sda_p_q <= sda_s_q;
      // Floating straps are pulled low at the pad
      strap_m_q <= {select_strap_bit2, select_strap_bit1, select_strap_bit0};
      strap_s_q <= strap_m_q;
    end
  end

  // Done toggle back from the programming domain
  always_ff @(posedge link_clk or negedge lrst_q) begin
    if (!lrst_q) begin
      done_m_q <= 1'b0;
      done_s_q <= 1'b0;
      done_p_q <= 1'b0;
    end else begin
      done_m_q <= done_tgl;
      done_s_q <= done_m_q;
      done_p_q <= done_s_q;
    end
  end

  // Bus events from the sampled lines
  assign scl_rise = scl_s_q & ~scl_p_q;
  assign scl_fall = ~scl_s_q & scl_p_q;
  assign start_det = scl_s_q & scl_p_q & sda_p_q & ~sda_s_q;
  assign stop_det = scl_s_q & scl_p_q & ~sda_p_q & sda_s_q;
  assign done_evt = done_s_q ^ done_p_q;

  // Byte decision at the falling edge ending the eighth bit
  assign byte_done = (state_q == SEPW_RX) & scl_fall & (bit_cnt_q == `SEPW_BIT_LAST);
  assign addr_hit = (shreg_q[BW-1:`SEPW_TYPE_LSB] == DEV_TYPE)
                    & (shreg_q[`SEPW_SEL_LSB +: `SEPW_SEL_W] == strap_s_q)
                    & ~busy_q;
  assign give_ack = byte_done & ((byte_idx_q != SEPW_IDX_DEV) | addr_hit);
  assign store_data = give_ack & (byte_idx_q == SEPW_IDX_DATA);

  // Link state machine, shifter and acknowledge driver
  always_ff @(posedge link_clk or negedge lrst_q) begin
    if (!lrst_q) begin
      state_q <= SEPW_IDLE;
      bit_cnt_q <= '0;
      byte_idx_q <= SEPW_IDX_DEV;
      shreg_q <= '0;
      rd_q <= 1'b0;
      sda_oe_q <= 1'b0;
    end else if (start_det) begin
      state_q <= SEPW_RX;
      bit_cnt_q <= '0;
      byte_idx_q <= SEPW_IDX_DEV;
      rd_q <= 1'b0;
      sda_oe_q <= 1'b0;
    end else if (stop_det) begin
      state_q <= SEPW_IDLE;
      sda_oe_q <= 1'b0;
    end else begin
      unique case (state_q)
        SEPW_IDLE, SEPW_WAIT: begin
        end
        SEPW_RX: begin
          if (scl_rise && bit_cnt_q != `SEPW_BIT_LAST) begin
            shreg_q <= {shreg_q[BW-2:0], sda_s_q};
            bit_cnt_q <= bit_cnt_q + 4'h1;
          end else if (byte_done) begin
            if (give_ack) begin
              state_q <= SEPW_ACK;
              sda_oe_q <= 1'b1;
              rd_q <= (byte_idx_q == SEPW_IDX_DEV) & shreg_q[`SEPW_RW_BIT];
              if (byte_idx_q != SEPW_IDX_DATA) begin
                byte_idx_q <= sepw_idx_t'(byte_idx_q + 2'h1);
              end
            end else begin
              state_q <= SEPW_WAIT;
            end
          end
        end
        SEPW_ACK: begin
          // Hold low through the ninth pulse, let go as it falls
          if (scl_fall) begin
            sda_oe_q <= 1'b0;
            bit_cnt_q <= '0;
            state_q <= rd_q ? SEPW_WAIT : SEPW_RX;
          end
        end
      endcase
    end
  end

  // Open drain: the driven level is always low
  always_ff @(posedge link_clk or negedge lrst_q) begin
    if (!lrst_q) begin
      sda_out_q <= 1'b0;
    end else begin
      sda_out_q <= 1'b0;
    end
  end

  // Address counter; high word-address bits beyond the array dropped
  always_ff @(posedge link_clk or negedge lrst_q) begin
    if (!lrst_q) begin
      addr_cnt_q <= '0;
    end else if (give_ack && byte_idx_q == SEPW_IDX_HI) begin
      addr_cnt_q[ADDR_W-1:BW] <= shreg_q[ADDR_W-BW-1:0];
    end else if (give_ack && byte_idx_q == SEPW_IDX_LO) begin
      addr_cnt_q[BW-1:0] <= shreg_q;
    end else if (store_data) begin
      // Only the in-page bits move, so a long burst wraps
      addr_cnt_q[PW-1:0] <= addr_cnt_q[PW-1:0] + PW'(1);
    end
  end

  // Page buffer; frozen while busy because nothing is acknowledged
  always_ff @(posedge link_clk or negedge lrst_q) begin
    if (!lrst_q) begin
      buf_q <= '0;
      mask_q <= '0;
      data_seen_q <= 1'b0;
    end else if (give_ack && byte_idx_q == SEPW_IDX_DEV) begin
      mask_q <= '0;
      data_seen_q <= 1'b0;
    end else if (store_data) begin
      buf_q[addr_cnt_q[PW-1:0]] <= shreg_q;
      mask_q[addr_cnt_q[PW-1:0]] <= 1'b1;
      data_seen_q <= 1'b1;
    end else if (stop_det) begin
      data_seen_q <= 1'b0;
    end
  end

  // Busy handshake: request toggle out, done toggle back
  always_ff @(posedge link_clk or negedge lrst_q) begin
    if (!lrst_q) begin
      busy_q <= 1'b0;
      req_tgl_q <= 1'b0;
    end else if (stop_det && data_seen_q && !busy_q) begin
      busy_q <= 1'b1;
      req_tgl_q <= ~req_tgl_q;
    end else if (done_evt) begin
      busy_q <= 1'b0;
    end
  end

  sepw_prog #(
    .ADDR_W(ADDR_W),
    .PROG_CYCLES(PROG_CYCLES)
  ) u_prog (
    .clk(clk),
    .reset_n(reset_n),
    .req_tgl(req_tgl_q),
    .wp_pin(write_protect),
    .page_i(addr_cnt_q[ADDR_W-1:PW]),
    .data_i(buf_q),
    .mask_i(mask_q),
    .rd_addr(mem_rd_addr),
    .rd_data_q(mem_rd_data),
    .busy_q(prog_busy),
    .done_tgl_q(done_tgl)
  );

  assign sda_out = sda_out_q;
  assign sda_oe = sda_oe_q;

  // Checks on the link side

  property p_ack_match;
    @(posedge link_clk) disable iff (!lrst_q)
    byte_done && byte_idx_q == SEPW_IDX_DEV && addr_hit |=> sda_oe_q && state_q == SEPW_ACK;
  endproperty
  a_ack_match: assert property (p_ack_match) else $error("match not acknowledged");

  property p_type_gate;
    @(posedge link_clk) disable iff (!lrst_q)
    byte_done && byte_idx_q == SEPW_IDX_DEV && shreg_q[BW-1:`SEPW_TYPE_LSB] != DEV_TYPE |=> !sda_oe_q;
  endproperty
  a_type_gate: assert property (p_type_gate) else $error("wrong type acknowledged");

  property p_sel_gate;
    @(posedge link_clk) disable iff (!lrst_q)
    byte_done && byte_idx_q == SEPW_IDX_DEV && shreg_q[`SEPW_SEL_LSB +: `SEPW_SEL_W] != strap_s_q
      |=> state_q == SEPW_WAIT && !sda_oe_q;
  endproperty
  a_sel_gate: assert property (p_sel_gate) else $error("strap mismatch acknowledged");

  property p_busy_quiet;
    @(posedge link_clk) disable iff (!lrst_q)
    busy_q && $past(busy_q) |-> !sda_oe_q;
  endproperty
  a_busy_quiet: assert property (p_busy_quiet) else $error("answered while busy");

  property p_ack_hold;
    @(posedge link_clk) disable iff (!lrst_q)
    state_q == SEPW_ACK && !scl_fall && !start_det && !stop_det |=> sda_oe_q;
  endproperty
  a_ack_hold: assert property (p_ack_hold) else $error("ack released early");

  property p_start_rx;
    @(posedge link_clk) disable iff (!lrst_q)
    start_det |=> state_q == SEPW_RX && bit_cnt_q == 4'h0 && !sda_oe_q;
  endproperty
  a_start_rx: assert property (p_start_rx) else $error("start not taken");

  property p_stop_idle;
    @(posedge link_clk) disable iff (!lrst_q)
    stop_det && !start_det |=> state_q == SEPW_IDLE ##1 !sda_oe_q;
  endproperty
  a_stop_idle: assert property (p_stop_idle) else $error("stop not taken");

  property p_page_step;
    @(posedge link_clk) disable iff (!lrst_q)
    store_data |=> addr_cnt_q[ADDR_W-1:PW] == $past(addr_cnt_q[ADDR_W-1:PW])
      && addr_cnt_q[PW-1:0] == $past(addr_cnt_q[PW-1:0]) + PW'(1);
  endproperty
  a_page_step: assert property (p_page_step) else $error("page address step wrong");

  property p_prog_req;
    @(posedge link_clk) disable iff (!lrst_q)
    stop_det && data_seen_q && !busy_q |=> busy_q && req_tgl_q != $past(req_tgl_q);
  endproperty
  a_prog_req: assert property (p_prog_req) else $error("no cycle after write");

  property p_no_abort_prog;
    @(posedge link_clk) disable iff (!lrst_q)
    stop_det && !data_seen_q |=> $stable(req_tgl_q);
  endproperty
  a_no_abort_prog: assert property (p_no_abort_prog) else $error("cycle after empty write");

  property p_miss_release;
    @(posedge link_clk) disable iff (!lrst_q)
    state_q == SEPW_WAIT && !start_det |=> !sda_oe_q;
  endproperty
  a_miss_release: assert property (p_miss_release) else $error("line held when unselected");

  c_byte_write: cover property (@(posedge link_clk) disable iff (!lrst_q)
    stop_det && data_seen_q && !busy_q);
  c_poll_nack: cover property (@(posedge link_clk) disable iff (!lrst_q)
    byte_done && byte_idx_q == SEPW_IDX_DEV && busy_q);
  c_page_wrap: cover property (@(posedge link_clk) disable iff (!lrst_q)
    store_data && addr_cnt_q[PW-1:0] == '1);
  c_read_sel: cover property (@(posedge link_clk) disable iff (!lrst_q)
    give_ack && byte_idx_q == SEPW_IDX_DEV && shreg_q[`SEPW_RW_BIT]);

endmodule

`default_nettype wire

// ==== verilog/sepw_defs.svh ====
/*
  Constants of the two-wire page-write slave.
  Assumes inclusion by bare name from the design files.
*/
// Operation
// - Array is byte wide, 8192 or 4096 bytes deep.
// - Write-protect high blocks programming of the upper array half.
// - Write-protect low lets the whole array be programmed.
// - Select straps default low; eight devices may share a bus.
// - Data changes with clock high are start or stop conditions.
// - One clock pulse per bit, sampled while clock is high.
// - Start is data falling with clock high; nothing happens before it.
// - Stop is data rising with clock high; it ends every operation.
// - A receiver acknowledges a byte by pulling data low one pulse.
// - Address byte is 8 bits; top four must match device type.
// - Next three address bits must equal the strap levels.
// - Last address bit: one reads, zero writes.
// - On a match the device pulls data low in the ninth clock.
// - Byte write is address, two word-address bytes, one data byte.
// - Stop after a write starts programming; no answers until done.
// - Programming is self timed, at most 5 ms, clears itself.
// - Page write takes up to 31 more bytes, each acknowledged.
// - Each data byte bumps only the five low address bits.
// - Over 32 bytes the page address wraps and overwrites.
// - All buffered bytes are programmed in one cycle after stop.
// - While busy the address byte gets no acknowledge.
// - Address counter holds last accessed address plus one.
`ifndef SEPW_DEFS_SVH
`define SEPW_DEFS_SVH

`define SEPW_BYTE_W 8
`define SEPW_PAGE_W 5
`define SEPW_PAGE_BYTES 32
`define SEPW_ADDR_W 13
`define SEPW_ADDR_W_MIN 9
`define SEPW_ADDR_W_MAX 16
`define SEPW_TYPE_LSB 4
`define SEPW_SEL_LSB 1
`define SEPW_SEL_W 3
`define SEPW_RW_BIT 0
`define SEPW_BIT_LAST 4'h8
`define SEPW_T_PROG_US 5000
`define SEPW_CLK_MHZ 100
// Device-type code: arbitrary neutral value
`define SEPW_DEV_TYPE_DFLT 4'h6

`endif

// ==== verilog/sepw_pkg.sv ====
/*
  Types of the two-wire page-write slave.
  Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none

package sepw_pkg;

  typedef logic [7:0] sepw_byte_t;

  // Link states, Gray order idle-rx-ack-wait
  typedef enum logic [1:0] {
    SEPW_IDLE = 2'h0,
    SEPW_RX = 2'h1,
    SEPW_ACK = 2'h3,
    SEPW_WAIT = 2'h2
  } sepw_state_t;

  // Position of the byte within a write
  typedef enum logic [1:0] {
    SEPW_IDX_DEV = 2'h0,
    SEPW_IDX_HI = 2'h1,
    SEPW_IDX_LO = 2'h2,
    SEPW_IDX_DATA = 2'h3
  } sepw_idx_t;

endpackage

`default_nettype wire

// ==== verilog/sepw_prog.sv ====
/*
  Programming engine: byte array and self-timed write cycle.
  Assumes page data, mask and page address stay still from a
  request toggle until the done toggle returns.
*/
`default_nettype none
`include "sepw_defs.svh"

module sepw_prog
#(
  parameter int ADDR_W = `SEPW_ADDR_W,
  parameter int PROG_CYCLES = `SEPW_T_PROG_US * `SEPW_CLK_MHZ
)(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic req_tgl,
  input wire logic wp_pin,
  input wire logic [ADDR_W-`SEPW_PAGE_W-1:0] page_i,
  input wire logic [`SEPW_PAGE_BYTES-1:0][`SEPW_BYTE_W-1:0] data_i,
  input wire logic [`SEPW_PAGE_BYTES-1:0] mask_i,
  input wire logic [ADDR_W-1:0] rd_addr,
  output var sepw_pkg::sepw_byte_t rd_data_q,
  output logic busy_q,
  output logic done_tgl_q
);
  import sepw_pkg::*;

  localparam int CNT_W = $clog2(PROG_CYCLES + 1);
  localparam int PG_W = ADDR_W - `SEPW_PAGE_W;

  sepw_byte_t mem_q [2**ADDR_W];
  logic req_m_q, req_s_q, req_p_q;
  logic wp_m_q, wp_s_q;
  logic [CNT_W-1:0] cnt_q;
  logic start_pulse, wp_block;

  // Toggle and pin synchronisers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      req_m_q <= 1'b0;
      req_s_q <= 1'b0;
      req_p_q <= 1'b0;
      wp_m_q <= 1'b0;
      wp_s_q <= 1'b0;
    end else begin
      req_m_q <= req_tgl;
      req_s_q <= req_m_q;
      req_p_q <= req_s_q;
      wp_m_q <= wp_pin;
      wp_s_q <= wp_m_q;
    end
  end

  assign start_pulse = req_s_q ^ req_p_q;
  assign wp_block = wp_s_q & page_i[PG_W-1];

  // Whole page lands in one go; untouched slots keep old data
  always_ff @(posedge clk) begin
    if (start_pulse && !wp_block) begin
      for (int i = 0; i < `SEPW_PAGE_BYTES; i++) begin
        if (mask_i[i]) begin
          mem_q[{page_i, `SEPW_PAGE_W'(i)}] <= data_i[i];
        end
      end
    end
  end

  // Self-timed cycle, no master action needed to end it
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      busy_q <= 1'b0;
      cnt_q <= '0;
      done_tgl_q <= 1'b0;
    end else if (start_pulse) begin
      busy_q <= 1'b1;
      cnt_q <= '0;
    end else if (busy_q) begin
      if (cnt_q == CNT_W'(PROG_CYCLES - 1)) begin
        busy_q <= 1'b0;
        done_tgl_q <= ~done_tgl_q;
      end else begin
        cnt_q <= cnt_q + CNT_W'(1);
      end
    end
  end

  // Read-back port for inspection
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_data_q <= '0;
    end else begin
      rd_data_q <= mem_q[rd_addr];
    end
  end

  property p_prog_end;
    @(posedge clk) disable iff (!reset_n)
    busy_q && cnt_q == CNT_W'(PROG_CYCLES - 1) |=> !busy_q && done_tgl_q != $past(done_tgl_q);
  endproperty
  a_prog_end: assert property (p_prog_end) else $error("cycle did not end on time");

  property p_wp_hold;
    @(posedge clk) disable iff (!reset_n)
    start_pulse && wp_s_q && page_i[PG_W-1] |=> mem_q[{page_i, `SEPW_PAGE_W'(0)}] == $past(mem_q[{page_i,
      `SEPW_PAGE_W'(0)}]);
  endproperty
  a_wp_hold: assert property (p_wp_hold) else $error("protected byte changed");

endmodule

`default_nettype wire

// ==== tb/sepw_bus_master.sv ====
/*
  Behavioural bus master for the two-wire page-write slave bench.
  Assumes the bench resolves the open-drain data wire with a pull-up
  and feeds the resolved level back on sda_wire.
*/
`default_nettype none

module sepw_bus_master (
  input wire logic link_clk,
  input wire logic sda_wire,
  output logic scl,
  output logic sda_drive
);
  timeunit 1ns;
  timeprecision 1ps;

  // Each phase is twice the slave's minimum so its synchronisers settle
  localparam int HALF = 8;

  // Idle bus: clock high, data released to the pull-up
  initial begin
    scl = 1'b1;
    sda_drive = 1'b0;
  end

  task automatic hold();
    repeat (HALF) @(posedge link_clk);
  endtask

  // Data released and clock raised first, so a repeated start is also legal
  task automatic start();
    sda_drive <= 1'b0;
    hold();
    scl <= 1'b1;
    hold();
    sda_drive <= 1'b1;
    hold();
    scl <= 1'b0;
    hold();
  endtask

  // Data moves only mid low phase; sampled at the end of the high phase
  task automatic clock_bit(input logic b, output logic got);
    sda_drive <= !b;
    hold();
    scl <= 1'b1;
    hold();
    got = sda_wire;
    scl <= 1'b0;
    hold();
  endtask

  // Eight bits then a released ninth bit for the slave's answer
  task automatic send_byte(input logic [7:0] v, output logic ack);
    logic d;
    for (int i = 7; i >= 0; i--) begin
      clock_bit(v[i], d);
    end
    clock_bit(1'b1, d);
    ack = !d;
  endtask

  // Data pulled low under a low clock, then released while clock is high
  task automatic stop();
    sda_drive <= 1'b1;
    hold();
    scl <= 1'b1;
    hold();
    sda_drive <= 1'b0;
    hold();
    hold();
  endtask
endmodule

`default_nettype wire

// ==== tb/sepw_top_tb_top.sv ====
/*
  Self-checking bench for the two-wire page-write slave.
  Assumes a short programming count and the neutral device-type code.
*/
`default_nettype none

module sepw_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import sepw_pkg::*;

  typedef struct {logic [15:0] wa; logic [7:0] d; logic wp; logic [12:0] ra; logic [7:0] exp;} sepw_row_t;

  logic clk, link_clk, reset_n, write_protect, scl, m_drive, sda_oe, sda_out, prog_busy;
  logic [2:0] straps;
  logic [12:0] mem_rd_addr;
  sepw_byte_t mem_rd_data;
  int bad_count, checks, cycles;
  logic a, seen;
  // Open-drain wire with pull-up: low while either party pulls; the slave only pulls when its driven level is low
  wire logic sda_wire = !((sda_oe & !sda_out) | m_drive);

  // Byte writes: word address, data, protect, read-back address, expected byte
  sepw_row_t rows [6] = '{
    '{16'h0010, 8'h5A, 1'b0, 13'h0010, 8'h5A},
    '{16'h1020, 8'h11, 1'b0, 13'h1020, 8'h11},
    '{16'h1020, 8'h22, 1'b1, 13'h1020, 8'h11},
    '{16'h0030, 8'h33, 1'b1, 13'h0030, 8'h33},
    '{16'hE045, 8'hC3, 1'b0, 13'h0045, 8'hC3},
    '{16'h1FFF, 8'h7E, 1'b0, 13'h1FFF, 8'h7E}
  };

  sepw_top #(.PROG_CYCLES(200), .DEV_TYPE(4'h6)) u_dut (
    .clk(clk),
    .reset_n(reset_n),
    .link_clk(link_clk),
    .scl_in(scl),
    .sda_in(sda_wire),
    .sda_out(sda_out),
    .sda_oe(sda_oe),
    .select_strap_bit0(straps[0]),
    .select_strap_bit1(straps[1]),
    .select_strap_bit2(straps[2]),
    .write_protect(write_protect),
    .mem_rd_addr(mem_rd_addr),
    .mem_rd_data(mem_rd_data),
    .prog_busy(prog_busy)
  );

  sepw_bus_master u_bus (
    .link_clk(link_clk),
    .sda_wire(sda_wire),
    .scl(scl),
    .sda_drive(m_drive)
  );

  // System clock and an unrelated link sampling clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    link_clk = 1'b0;
    #1.7;
    forever #3 link_clk = ~link_clk;
  end

  task automatic summarize();
    if (bad_count == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Ceiling well above the expected run of about 15000 cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      bad_count++;
      $display("CHECK FAILED at %0t: run did not finish", $time);
      summarize();
    end
  end

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic dev_addr(input logic [3:0] typ, input logic [2:0] sel, input logic rw, output logic ack);
    u_bus.start();
    u_bus.send_byte({typ, sel, rw}, ack);
  endtask

  // Full write: address byte, two word-address bytes, n data bytes, stop
  task automatic write_seq(input logic [15:0] wa, input logic [7:0] first, input int n);
    logic k_ack;
    dev_addr(4'h6, straps, 1'b0, k_ack);
    chk8({7'h00, k_ack}, 8'h01, "address ack");
    u_bus.send_byte(wa[15:8], k_ack);
    chk8({7'h00, k_ack}, 8'h01, "word high ack");
    u_bus.send_byte(wa[7:0], k_ack);
    chk8({7'h00, k_ack}, 8'h01, "word low ack");
    for (int k = 0; k < n; k++) begin
      u_bus.send_byte(first + 8'(k), k_ack);
      chk8({7'h00, k_ack}, 8'h01, "data ack");
    end
    u_bus.stop();
  endtask

  // Bounded wait for one programming cycle to come and go
  task automatic wait_done(output logic hit);
    hit = 1'b0;
    for (int n = 0; n < 600 && !(hit && prog_busy === 1'b0); n++) begin
      @(posedge clk);
      if (prog_busy === 1'b1) hit = 1'b1;
    end
    repeat (4) @(posedge clk);
  endtask

  // Read-back port has one cycle of latency; allow margin
  task automatic rd_check(input logic [12:0] ra, input logic [7:0] exp);
    @(posedge clk);
    mem_rd_addr <= ra;
    repeat (3) @(posedge clk);
    chk8(mem_rd_data, exp, "array byte");
  endtask

  // A bus sequence that must not start programming
  task automatic expect_idle(input string what);
    logic hit;
    hit = 1'b0;
    repeat (60) begin
      @(posedge clk);
      if (prog_busy !== 1'b0) hit = 1'b1;
    end
    chk8({7'h00, hit}, 8'h00, what);
  endtask

  initial begin
    reset_n = 1'b0;
    write_protect = 1'b0;
    straps = 3'h0;
    mem_rd_addr = 13'h0000;
    bad_count = 0;
    checks = 0;
    cycles = 0;
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    repeat (10) @(posedge clk);
    chk8({5'h00, sda_out, sda_oe, prog_busy}, 8'h00, "idle outputs after reset");
    // Table of byte writes, each read back; the protected upper-half one keeps old data
    foreach (rows[i]) begin
      @(posedge clk);
      write_protect <= rows[i].wp;
      repeat (4) @(posedge clk);
      write_seq(rows[i].wa, rows[i].d, 1);
      wait_done(seen);
      if (rows[i].wp === 1'b0) chk8({7'h00, seen}, 8'h01, "programming ran");
      rd_check(rows[i].ra, rows[i].exp);
    end
    @(posedge clk);
    write_protect <= 1'b0;
    // Wrong device type is never answered
    dev_addr(4'h5, straps, 1'b0, a);
    chk8({7'h00, a}, 8'h00, "foreign type ack");
    u_bus.stop();
    // Every strap setting: exact match answered, a mismatch ignored, no write after bare address
    for (int s = 0; s < 8; s++) begin
      @(posedge clk);
      straps <= 3'(s);
      repeat (4) @(posedge clk);
      dev_addr(4'h6, 3'(s), 1'b0, a);
      chk8({7'h00, a}, 8'h01, "strap match ack");
      u_bus.stop();
      expect_idle("address-only write programmed");
      dev_addr(4'h6, 3'(s) ^ 3'h5, 1'b0, a);
      chk8({7'h00, a}, 8'h00, "strap mismatch ack");
      u_bus.stop();
    end
    // Read direction is still answered
    dev_addr(4'h6, straps, 1'b1, a);
    chk8({7'h00, a}, 8'h01, "read address ack");
    u_bus.stop();
    // Poll straight after the stop: refused while busy, answered once done
    write_seq(16'h0100, 8'hA0, 1);
    dev_addr(4'h6, straps, 1'b0, a);
    chk8({7'h00, a}, 8'h00, "ack while busy");
    u_bus.stop();
    a = 1'b0;
    for (int t = 0; t < 10 && a !== 1'b1; t++) begin
      dev_addr(4'h6, straps, 1'b0, a);
      u_bus.stop();
    end
    chk8({7'h00, a}, 8'h01, "ack after programming");
    rd_check(13'h0100, 8'hA0);
    // 33 bytes from offset 0x1E of a page: low five bits wrap, last byte overwrites the first
    write_seq(16'h025E, 8'h80, 33);
    wait_done(seen);
    chk8({7'h00, seen}, 8'h01, "page programmed");
    rd_check(13'h025E, 8'hA0);
    rd_check(13'h025F, 8'h81);
    rd_check(13'h0240, 8'h82);
    rd_check(13'h025D, 8'h9F);
    // Stop in mid data byte: nothing is programmed and old data stays
    dev_addr(4'h6, straps, 1'b0, a);
    u_bus.send_byte(8'h00, a);
    u_bus.send_byte(8'h10, a);
    repeat (4) u_bus.clock_bit(1'b0, a);
    u_bus.stop();
    expect_idle("partial byte programmed");
    rd_check(13'h0010, 8'h5A);
    summarize();
  end
endmodule

`default_nettype wire
